// ---- design/ijx_pkg.sv ----
// ijx_pkg: opcode fields, encodings and widths for the inc/dec/jump executor
// assumes 14-bit instruction words and a 13-bit program counter
package ijx_pkg;
  localparam int          INSN_W      = 14;
  localparam int          DATA_W      = 8;
  localparam int          FADDR_W     = 7;
  localparam int          PC_W        = 13;
  localparam int          JMP_W       = 11;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int          OP_HI       = 13;
  localparam int          OP_LO       = 8;
  localparam int          JOP_LO      = 11;
  localparam int          DEST_BIT    = 7;
  localparam int          LATCH_HI    = 4;
  localparam int          LATCH_LO    = 3;
  // -------------------------------------------------------------
  // encodings
  // -------------------------------------------------------------
  localparam logic [5:0]  OP_DEC_FILE = 6'h03;
  localparam logic [5:0]  OP_INC_FILE = 6'h0A;
  localparam logic [2:0]  OP_JUMP     = 3'h5;
  localparam logic [7:0]  ONE_DATA    = 8'h01;
  localparam logic [7:0]  ZERO_DATA   = 8'h00;
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [12:0] PC_STEP     = 13'h0001;

  typedef enum logic [0:0] {IJX_RUN, IJX_FLUSH} ijx_state_t;
endpackage : ijx_pkg

// ---- design/ijx_exec.sv ----
// ijx_exec: decode and execute of file decrement, file increment, absolute jump
// assumes one instruction word per clk_sys cycle from program memory and a
// combinational file read port addressed by file_addr
// the array writes file_wdata at file_waddr on the edge that ends file_we
//
// Overview of operation
// (RL1) decrement file, write destination, update zero
// (RL2) increment file, write destination, update zero
// (RL3) destination bit 0 accumulator, 1 file
// (RL4) jump loads 11-bit immediate into pc
// (RL5) jump copies latch bits 4:3, flags kept
// (RL6) jump takes two cycles, second is nop
// (RL7) low seven bits address, bit7 destination
`timescale 1ns/1ps
module ijx_exec (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // instruction fetch
  input  wire logic [13:0] insn,
  output logic      [12:0] pc,
  // file register array
  output logic      [6:0]  file_addr,
  input  wire logic [7:0]  file_rdata,
  output logic             file_we,
  output logic      [7:0]  file_wdata,
  // file write-back address, held with the write pulse
  output logic      [6:0]  file_waddr,
  // accumulator
  output logic             acc_we,
  output logic      [7:0]  acc_wdata,
  // status zero flag
  output logic             zero_we,
  output logic             zero_val,
  // page latch
  input  wire logic [7:0]  upper_page_latch
);
  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  ijx_pkg::ijx_state_t state_reg;
  ijx_pkg::ijx_state_t state_next;
  logic [12:0]         pc_reg;
  logic [12:0]         pc_next;
  logic                is_dec;
  logic                is_inc;
  logic                is_jump;
  logic                dest_file;
  logic                fwd_hit;
  logic [7:0]          rd_operand;
  logic [7:0]          result;
  logic                file_we_reg;
  logic                file_we_next;
  logic                acc_we_reg;
  logic                acc_we_next;
  logic                zero_we_reg;
  logic                zero_we_next;
  logic                zero_reg;
  logic                zero_next;
  logic [7:0]          wdata_reg;
  logic [7:0]          wdata_next;
  logic [6:0]          waddr_reg;
  logic [6:0]          waddr_next;

  // flush cycle ignores the word fetched at the jump target; that word is fetched and decoded again next cycle
  assign is_dec    = state_reg == ijx_pkg::IJX_RUN &&
                     insn[ijx_pkg::OP_HI:ijx_pkg::OP_LO] == ijx_pkg::OP_DEC_FILE;
  assign is_inc    = state_reg == ijx_pkg::IJX_RUN &&
                     insn[ijx_pkg::OP_HI:ijx_pkg::OP_LO] == ijx_pkg::OP_INC_FILE;
  assign is_jump   = state_reg == ijx_pkg::IJX_RUN &&
                     insn[ijx_pkg::OP_HI:ijx_pkg::JOP_LO] == ijx_pkg::OP_JUMP;
  assign dest_file = insn[ijx_pkg::DEST_BIT]; // RL7
  assign file_addr = insn[ijx_pkg::FADDR_W-1:0]; // RL7

  // ------------------------------------------------------------------
  // operand forwarding
  // ------------------------------------------------------------------
  // the array is written two edges after decode, so a read of the address
  // still waiting for write-back would see stale data; take the pending byte
  assign fwd_hit    = file_we_reg && waddr_reg == file_addr; // RL1 RL2
  assign rd_operand = fwd_hit ? wdata_reg : file_rdata;
  assign result     = is_dec ? rd_operand - ijx_pkg::ONE_DATA // RL1
                             : rd_operand + ijx_pkg::ONE_DATA; // RL2

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next   = ijx_pkg::IJX_RUN;
    pc_next      = pc_reg + ijx_pkg::PC_STEP;
    file_we_next = 1'b0;
    acc_we_next  = 1'b0;
    zero_we_next = 1'b0; // RL5
    zero_next    = zero_reg;
    wdata_next   = wdata_reg;
    waddr_next   = waddr_reg;
    case (state_reg)
      ijx_pkg::IJX_RUN: begin
        if (is_jump) begin
          pc_next    = {upper_page_latch[ijx_pkg::LATCH_HI:ijx_pkg::LATCH_LO], // RL5
                        insn[ijx_pkg::JMP_W-1:0]}; // RL4
          state_next = ijx_pkg::IJX_FLUSH; // RL6
        end else if (is_dec || is_inc) begin
          file_we_next = dest_file; // RL3
          acc_we_next  = !dest_file; // RL3
          zero_we_next = 1'b1; // RL1 RL2
          zero_next    = result == ijx_pkg::ZERO_DATA; // RL1 RL2
          wdata_next   = result;
          waddr_next   = file_addr;
        end
      end
      // the word shown now is dropped; hold pc so that the target word is
      // fetched again and decoded in the next cycle
      ijx_pkg::IJX_FLUSH: begin
        pc_next    = pc_reg; // RL6
        state_next = ijx_pkg::IJX_RUN; // RL6
      end
      default:            state_next = ijx_pkg::IJX_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ijx_pkg::IJX_RUN;
      pc_reg      <= ijx_pkg::PC_RESET;
      file_we_reg <= 1'b0;
      acc_we_reg  <= 1'b0;
      zero_we_reg <= 1'b0;
      zero_reg    <= 1'b0;
      wdata_reg   <= ijx_pkg::ZERO_DATA;
      waddr_reg   <= ijx_pkg::ZERO_DATA[ijx_pkg::FADDR_W-1:0];
    end else begin
      state_reg   <= state_next;
      pc_reg      <= pc_next;
      file_we_reg <= file_we_next;
      acc_we_reg  <= acc_we_next;
      zero_we_reg <= zero_we_next;
      zero_reg    <= zero_next;
      wdata_reg   <= wdata_next;
      waddr_reg   <= waddr_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // write-back is registered, one cycle after decode; file_addr during it
  // belongs to the next word, so the write uses file_waddr instead
  assign pc         = pc_reg;
  assign file_waddr = waddr_reg; // RL7
  assign file_we    = file_we_reg;
  assign file_wdata = wdata_reg;
  assign acc_we     = acc_we_reg;
  assign acc_wdata  = wdata_reg;
  assign zero_we    = zero_we_reg;
  assign zero_val   = zero_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  dec_result_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL1
    is_dec |=> wdata_reg == $past(rd_operand) - ijx_pkg::ONE_DATA && zero_we)
    else $error("decrement result wrong");
  inc_result_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL2
    is_inc |=> wdata_reg == $past(rd_operand) + ijx_pkg::ONE_DATA
               && zero_val == (wdata_reg == ijx_pkg::ZERO_DATA))
    else $error("increment result or zero wrong");
  dest_select_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL3
    (is_inc || is_dec) |=> (file_we == $past(dest_file)) && (acc_we != file_we))
    else $error("destination select wrong");
  jump_low_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL4
    is_jump |=> pc[10:0] == $past(insn[10:0]))
    else $error("jump target low bits wrong");
  jump_page_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL5
    is_jump |=> pc[12:11] == $past(upper_page_latch[4:3]) && !zero_we)
    else $error("jump page or flags wrong");
  jump_flush_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL6
    is_jump |=> state_reg == ijx_pkg::IJX_FLUSH ##1
                (state_reg == ijx_pkg::IJX_RUN && !file_we && !acc_we && !zero_we))
    else $error("jump second cycle not a nop");
  addr_field_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL7
    (is_inc || is_dec) && dest_file |=> waddr_reg == $past(insn[6:0]) ##1 !file_we
      || $past(is_inc || is_dec))
    else $error("file address field wrong");
  single_cycle_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL7
    (is_inc || is_dec) |=> state_reg == ijx_pkg::IJX_RUN && pc == $past(pc) + 13'h0001)
    else $error("inc/dec not single cycle");

  flush_pc_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL6
    state_reg == ijx_pkg::IJX_FLUSH |=> pc == $past(pc))
    else $error("pc moved during jump flush");
  fwd_operand_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL1 RL2
    file_we && file_waddr == file_addr |-> rd_operand == file_wdata)
    else $error("pending write-back not forwarded");
  write_addr_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL3
    (is_inc || is_dec) && dest_file |=> file_we && file_waddr == $past(file_addr))
    else $error("write-back address wrong");
  dest_acc_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL3
    (is_inc || is_dec) && !dest_file |=> acc_we && !file_we)
    else $error("accumulator destination wrong");
  other_quiet_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL7
    state_reg == ijx_pkg::IJX_RUN && !is_inc && !is_dec && !is_jump
    |=> !file_we && !acc_we && !zero_we && pc == $past(pc) + ijx_pkg::PC_STEP)
    else $error("other word caused a write or pc jump");
  result_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL5
    !(is_inc || is_dec) |=> $stable(file_wdata) && $stable(zero_val))
    else $error("result or zero changed without inc/dec");
  zero_match_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL1 RL2
    zero_we |-> zero_val == (file_wdata == ijx_pkg::ZERO_DATA))
    else $error("zero flag does not match result");
  jump_no_write_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RL5
    is_jump |=> !file_we && !acc_we)
    else $error("jump wrote a destination");

  // ------------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------------
  dec_cov_c:   cover property (@(posedge clk_sys) disable iff (!resetn) is_dec ##1 zero_val);
  inc_cov_c:   cover property (@(posedge clk_sys) disable iff (!resetn) is_inc && !dest_file);
  jump_cov_c:  cover property (@(posedge clk_sys) disable iff (!resetn) is_jump ##2 is_jump);
  fwd_cov_c:   cover property (@(posedge clk_sys) disable iff (!resetn) fwd_hit && is_inc);
  flush_cov_c: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == ijx_pkg::IJX_FLUSH ##1 is_inc);
endmodule : ijx_exec

// ---- tb/ijx_prog_mem.sv ----
// ijx_prog_mem: program memory model feeding the executor
// assumes a registered pc; words read out combinationally, unwritten ones are x
`timescale 1ns/1ps
module ijx_prog_mem (
  // fetch
  pc,
  insn
);
  input  wire logic [12:0] pc;
  output logic      [13:0] insn;
  logic             [13:0] mem [0:8191];
  assign insn = mem[pc];
endmodule : ijx_prog_mem

// ---- tb/test_inc_dec_jump_exec.sv ----
// test_inc_dec_jump_exec: self-checking bench for ijx_exec
// assumes ijx_pkg compiled first; the bench plays the file array and page latch
`timescale 1ns/1ps
module test_inc_dec_jump_exec;
  logic        clk_sys, resetn, file_we, acc_we, zero_we, zero_val;
  logic [13:0] insn;
  logic [12:0] pc;
  logic [6:0]  file_addr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, acc_wdata, upper_page_latch;
  int          n_errors = 0;
  int          samples_checked = 0;
  ijx_prog_mem prog (.pc(pc), .insn(insn));
  ijx_exec uut (.clk_sys(clk_sys), .resetn(resetn), .insn(insn), .pc(pc),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
    .file_wdata(file_wdata), .file_waddr(file_waddr), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .zero_we(zero_we),
    .zero_val(zero_val), .upper_page_latch(upper_page_latch));
  task check(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : check
  // one word through decode; we = {acc, file, zero}; pk checks pc stepped by one
  task step(input logic [13:0] w, input logic [7:0] rd, input logic [2:0] we,
            input logic [7:0] d, input logic zv, input logic pk);
    logic [12:0] p;
    p = pc;
    prog.mem[pc] = w;
    file_rdata = rd;
    #1;
    check("file_addr", {9'h000, w[6:0]}, {9'h000, file_addr});
    @(posedge clk_sys);
    #1;
    check("we", {13'h0000, we}, {13'h0000, acc_we, file_we, zero_we});
    if (we[0]) begin
      check("acc_wdata", {8'h00, d}, {8'h00, acc_wdata});
      check("file_wdata", {8'h00, d}, {8'h00, file_wdata});
      check("zero_val", {15'h0000, zv}, {15'h0000, zero_val});
    end
    if (we[1]) check("file_waddr", {9'h000, w[6:0]}, {9'h000, file_waddr});
    if (pk) check("pc", {3'h0, p + 13'h0001}, {3'h0, pc});
  endtask : step
  task t_dec;
    step(14'h0305, 8'h01, 3'b101, 8'h00, 1'b1, 1'b1);
    step(14'h03FF, 8'h00, 3'b011, 8'hFF, 1'b0, 1'b1);
    $display("test dec done");
  endtask : t_dec
  task t_inc;
    // array still shows the old byte of 0x7F; the pending 8'hFF must be used
    step(14'h0AFF, 8'h00, 3'b011, 8'h00, 1'b1, 1'b1);
    step(14'h0A00, 8'h0F, 3'b101, 8'h10, 1'b0, 1'b1);
    $display("test inc done");
  endtask : t_inc
  task t_jump;
    upper_page_latch = 8'h08;
    step(14'h2D55, 8'h00, 3'b000, 8'h00, 1'b0, 1'b0);
    check("pc", 16'h0D55, {3'h0, pc});
    step(14'h0A80, 8'h22, 3'b000, 8'h00, 1'b0, 1'b0);
    check("pc", 16'h0D55, {3'h0, pc});
    step(14'h0A00, 8'h00, 3'b101, 8'h01, 1'b0, 1'b1);
    upper_page_latch = 8'hF7;
    step(14'h2800, 8'h00, 3'b000, 8'h00, 1'b0, 1'b0);
    check("pc", 16'h1000, {3'h0, pc});
    step(14'h0A80, 8'h00, 3'b000, 8'h00, 1'b0, 1'b0);
    check("pc", 16'h1000, {3'h0, pc});
    $display("test jump done");
  endtask : t_jump
  task t_other;
    step(14'h0000, 8'h05, 3'b000, 8'h00, 1'b0, 1'b1);
    step(14'h0385, 8'h80, 3'b011, 8'h7F, 1'b0, 1'b1);
    $display("test other done");
  endtask : t_other
  task results;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    n_errors++;
    results;
  end
  initial begin
    resetn = 1'b0;
    file_rdata = 8'h00;
    upper_page_latch = 8'h00;
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_dec;
    t_inc;
    t_jump;
    t_other;
    results;
  end
endmodule : test_inc_dec_jump_exec
